// File: timer_capture_params.svh
// register offsets, field positions and reset values of the capture timer channel
`ifndef TIMER_CAPTURE_PARAMS_SVH
`define TIMER_CAPTURE_PARAMS_SVH

// byte offsets of the registers on the apb bus
`define OFS_ENABLE 8'h00
`define OFS_RUN 8'h04
`define OFS_MODE 8'h0C
`define OFS_FFCTRL 8'h10
`define OFS_STATUS 8'h14
`define OFS_MASK 8'h18
`define OFS_COMPARE0 8'h1C
`define OFS_COMPARE1 8'h20
`define OFS_CAPTURE0 8'h24
`define OFS_CAPTURE1 8'h28
`define OFS_COUNTER 8'h2C

// field positions
`define ENABLE_BIT 7
`define RUN_PRESCALE_BIT 2
`define RUN_COUNT_BIT 0
`define MODE_CLKSEL_HI 2
`define MODE_CLKSEL_LO 0
`define MODE_CLEAR_BIT 3
`define MODE_CPM_HI 5
`define MODE_CPM_LO 4
`define MODE_WIDTH 7
`define FF_TOGGLE1_BIT 3
`define FF_TOGGLE0_BIT 2
`define FF_CMD_HI 1
`define FF_CMD_LO 0
`define FF_WIDTH 4

// interrupt status and mask layout
`define ST_MATCH0 0
`define ST_MATCH1 1
`define ST_OVERFLOW 2
`define ST_CAPTURE0 3
`define ST_CAPTURE1 4
`define ST_WIDTH 5

// reset values, and the fixed read value of the flop command field
`define RST_MODE 7'h00
`define RST_FF 4'h0
`define RST_MASK 5'h00
`define FF_CMD_READ 2'h3

`endif

// File: timer_capture_pkg.sv
// types shared by the capture timer channel
package timer_capture_pkg;

    // capture trigger selection
    typedef enum logic [1:0] {
        CPM_OFF = 2'h0,
        CPM_PIN_RISE = 2'h1,
        CPM_PIN_BOTH = 2'h2,
        CPM_FLOP_BOTH = 2'h3
    } capture_mode_e;

    // counter source selection
    typedef enum logic [2:0] {
        CLK_PIN = 3'h0,
        CLK_TAP1 = 3'h1,
        CLK_TAP2 = 3'h2,
        CLK_TAP3 = 3'h3
    } clock_select_e;

    // software command to the toggle flip-flop
    typedef enum logic [1:0] {
        FF_INVERT = 2'h0,
        FF_SET = 2'h1,
        FF_CLEAR = 2'h2,
        FF_KEEP = 2'h3
    } ff_cmd_e;

endpackage

// File: edge_sync.sv
// two-flop synchroniser with rising and falling edge pulses
module edge_sync (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // asynchronous level and its edges
    input wire logic async_in,
    output logic rise,
    output logic fall
);

    logic meta;
    logic stable;
    logic last;

    // meta is read only by stable; edges look at stable and last
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= 1'b0;
            stable <= 1'b0;
            last <= 1'b0;
        end else begin
            meta <= async_in;
            stable <= meta;
            last <= stable;
        end
    end

    assign rise = stable & ~last;
    assign fall = ~stable & last;

endmodule

// File: prescaler_taps.sv
// prescaler producing one-cycle tick enables at three division ratios
module prescaler_taps #(
    parameter int TAP1_DIV = 2,
    parameter int TAP2_DIV = 8,
    parameter int TAP3_DIV = 32
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control and ticks
    input wire logic run,
    output logic [2:0] tick
);

    localparam int CW = $clog2(TAP3_DIV);

    // power-of-two ratios let each tap be a mask test on one counter
    if (TAP1_DIV < 2 || (TAP1_DIV & (TAP1_DIV - 1)) != 0 || (TAP2_DIV & (TAP2_DIV - 1)) != 0 ||
        (TAP3_DIV & (TAP3_DIV - 1)) != 0 || TAP2_DIV < TAP1_DIV || TAP3_DIV < TAP2_DIV) begin : g_bad
        $error("prescaler ratios must be rising powers of two");
    end

    logic [CW-1:0] count;
    logic [CW-1:0] next_count;

    // stopping clears the divider so a restart begins a full period
    always_comb begin
        next_count = run ? CW'(count + 1'b1) : '0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    assign tick[0] = run && ((count & CW'(TAP1_DIV - 1)) == CW'(TAP1_DIV - 1));
    assign tick[1] = run && ((count & CW'(TAP2_DIV - 1)) == CW'(TAP2_DIV - 1));
    assign tick[2] = run && ((count & CW'(TAP3_DIV - 1)) == CW'(TAP3_DIV - 1));

endmodule

// File: timer_capture_measure.sv
// capture/compare timer channel with apb registers and one interrupt
`include "timer_capture_params.svh"

module timer_capture_measure
    import timer_capture_pkg::*;
#(
    parameter int W = 16,
    parameter int TAP1_DIV = 2,
    parameter int TAP2_DIV = 8,
    parameter int TAP3_DIV = 32
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // measured pin and companion channel flop
    input wire logic ext_capture_input,
    input wire logic companion_toggle_in,
    // outputs
    output logic toggle_flipflop,
    output logic irq
);

    if (W < 2 || W > 32) begin : g_bad_width
        $error("counter width must lie between 2 and 32");
    end

    // address decode shared by read and write paths
    function automatic logic is_reg(input logic [7:0] addr, input logic [7:0] ofs);
        return addr == ofs;
    endfunction

    function automatic logic mapped(input logic [7:0] addr);
        return is_reg(addr, `OFS_ENABLE) || is_reg(addr, `OFS_RUN) || is_reg(addr, `OFS_MODE) ||
               is_reg(addr, `OFS_FFCTRL) || is_reg(addr, `OFS_STATUS) || is_reg(addr, `OFS_MASK) ||
               is_reg(addr, `OFS_COMPARE0) || is_reg(addr, `OFS_COMPARE1) ||
               is_reg(addr, `OFS_CAPTURE0) || is_reg(addr, `OFS_CAPTURE1) || is_reg(addr, `OFS_COUNTER);
    endfunction

    // software state
    logic enable_register;
    logic [1:0] run_register;
    logic [`MODE_WIDTH-1:0] mode_register;
    logic [`FF_WIDTH-1:0] flipflop_control;
    logic [`ST_WIDTH-1:0] interrupt_mask_register;
    logic [W-1:0] compare_reg_0;
    logic [W-1:0] compare_reg_1;
    logic next_enable;
    logic [1:0] next_run;
    logic [`MODE_WIDTH-1:0] next_mode;
    logic [`FF_WIDTH-1:0] next_ffctrl;
    logic [`ST_WIDTH-1:0] next_mask;
    logic [W-1:0] next_compare0;
    logic [W-1:0] next_compare1;

    // timer state
    logic [W-1:0] up_counter;
    logic [W-1:0] capture_reg_0;
    logic [W-1:0] capture_reg_1;
    logic companion_last;
    logic [W-1:0] next_counter;
    logic [W-1:0] next_capture0;
    logic [W-1:0] next_capture1;
    logic next_toggle;

    // interrupt state
    logic [`ST_WIDTH-1:0] status;
    logic [`ST_WIDTH-1:0] next_status;
    logic [`ST_WIDTH-1:0] events;

    // read path
    logic [31:0] next_prdata;
    logic next_pslverr;

    logic wr_access;
    logic setup;
    logic pin_rise;
    logic pin_fall;
    logic [2:0] tap_tick;
    logic prescale_run;
    logic count_run;
    logic count_tick;
    logic comp_rise;
    logic comp_fall;
    logic cap0_hit;
    logic cap1_hit;
    logic match0;
    logic match1;
    logic wrap;
    capture_mode_e cpm;
    clock_select_e clksel;
    ff_cmd_e ff_cmd;

    assign pready = 1'b1;
    assign setup = psel && !penable;
    assign wr_access = psel && penable && pwrite;
    assign cpm = capture_mode_e'(mode_register[`MODE_CPM_HI:`MODE_CPM_LO]);
    assign clksel = clock_select_e'(mode_register[`MODE_CLKSEL_HI:`MODE_CLKSEL_LO]);
    assign ff_cmd = ff_cmd_e'(pwdata[`FF_CMD_HI:`FF_CMD_LO]);

    // pin goes through two flops before any edge logic
    edge_sync u_pin (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(ext_capture_input),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    // both run bits and the channel enable gate the prescaler and counter
    assign prescale_run = enable_register && run_register[1] && run_register[0];
    assign count_run = prescale_run;

    prescaler_taps #(
        .TAP1_DIV(TAP1_DIV),
        .TAP2_DIV(TAP2_DIV),
        .TAP3_DIV(TAP3_DIV)
    ) u_prescaler (
        .pclk(pclk),
        .presetn(presetn),
        .run(prescale_run),
        .tick(tap_tick)
    );

    // counter source; reserved selections never advance the counter
    always_comb begin
        unique case (clksel)
            CLK_PIN: count_tick = count_run && pin_rise;
            CLK_TAP1: count_tick = count_run && tap_tick[0];
            CLK_TAP2: count_tick = count_run && tap_tick[1];
            CLK_TAP3: count_tick = count_run && tap_tick[2];
            default: count_tick = 1'b0;
        endcase
    end

    // companion flop comes from the same clock domain, so no synchroniser
    assign comp_rise = companion_toggle_in && !companion_last;
    assign comp_fall = !companion_toggle_in && companion_last;

    // capture triggers per capture mode
    always_comb begin
        unique case (cpm)
            CPM_OFF: begin
                cap0_hit = 1'b0;
                cap1_hit = 1'b0;
            end
            CPM_PIN_RISE: begin
                cap0_hit = pin_rise;
                cap1_hit = 1'b0;
            end
            CPM_PIN_BOTH: begin
                cap0_hit = pin_rise;
                cap1_hit = pin_fall;
            end
            CPM_FLOP_BOTH: begin
                cap0_hit = comp_rise;
                cap1_hit = comp_fall;
            end
        endcase
    end

    // matches are judged on the value the counter is about to take
    assign wrap = count_tick && (up_counter == {W{1'b1}});
    assign match0 = count_tick && (next_counter == compare_reg_0);
    assign match1 = count_tick && (next_counter == compare_reg_1);

    // counter, captures and toggle flop
    always_comb begin
        next_counter = up_counter;
        next_capture0 = capture_reg_0;
        next_capture1 = capture_reg_1;
        next_toggle = toggle_flipflop;
        if (!count_run) begin
            next_counter = '0;
        end else if (count_tick) begin
            if (mode_register[`MODE_CLEAR_BIT] && up_counter == compare_reg_1) begin
                next_counter = '0;
            end else begin
                next_counter = W'(up_counter + 1'b1);
            end
        end
        if (cap0_hit) begin
            next_capture0 = up_counter;
        end
        if (cap1_hit) begin
            next_capture1 = up_counter;
        end
        // each enable only acts on its own match; with both clear the level holds
        if ((match0 && flipflop_control[`FF_TOGGLE0_BIT]) ^ (match1 && flipflop_control[`FF_TOGGLE1_BIT])) begin
            next_toggle = !toggle_flipflop;
        end
        // a set, clear or invert command written in the same cycle overrides the match; a keep command lets the match toggle through
        if (wr_access && is_reg(paddr, `OFS_FFCTRL)) begin
            unique case (ff_cmd)
                FF_INVERT: next_toggle = !toggle_flipflop;
                FF_SET: next_toggle = 1'b1;
                FF_CLEAR: next_toggle = 1'b0;
                FF_KEEP: next_toggle = next_toggle;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            up_counter <= '0;
            capture_reg_0 <= '0;
            capture_reg_1 <= '0;
            toggle_flipflop <= 1'b0;
            companion_last <= 1'b0;
        end else begin
            up_counter <= next_counter;
            capture_reg_0 <= next_capture0;
            capture_reg_1 <= next_capture1;
            toggle_flipflop <= next_toggle;
            companion_last <= companion_toggle_in;
        end
    end

    // software-written registers
    always_comb begin
        next_enable = enable_register;
        next_run = run_register;
        next_mode = mode_register;
        next_ffctrl = flipflop_control;
        next_mask = interrupt_mask_register;
        next_compare0 = compare_reg_0;
        next_compare1 = compare_reg_1;
        if (wr_access) begin
            if (is_reg(paddr, `OFS_ENABLE)) begin
                next_enable = pwdata[`ENABLE_BIT];
            end
            if (is_reg(paddr, `OFS_RUN)) begin
                next_run = {pwdata[`RUN_PRESCALE_BIT], pwdata[`RUN_COUNT_BIT]};
            end
            if (is_reg(paddr, `OFS_MODE)) begin
                next_mode = pwdata[`MODE_WIDTH-1:0];
            end
            if (is_reg(paddr, `OFS_FFCTRL)) begin
                next_ffctrl = {pwdata[`FF_TOGGLE1_BIT], pwdata[`FF_TOGGLE0_BIT], 2'h0};
            end
            if (is_reg(paddr, `OFS_MASK)) begin
                next_mask = pwdata[`ST_WIDTH-1:0];
            end
            if (is_reg(paddr, `OFS_COMPARE0)) begin
                next_compare0 = pwdata[W-1:0];
            end
            if (is_reg(paddr, `OFS_COMPARE1)) begin
                next_compare1 = pwdata[W-1:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_register <= 1'b0;
            run_register <= 2'h0;
            mode_register <= `RST_MODE;
            flipflop_control <= `RST_FF;
            interrupt_mask_register <= `RST_MASK;
            compare_reg_0 <= '0;
            compare_reg_1 <= '0;
        end else begin
            enable_register <= next_enable;
            run_register <= next_run;
            mode_register <= next_mode;
            flipflop_control <= next_ffctrl;
            interrupt_mask_register <= next_mask;
            compare_reg_0 <= next_compare0;
            compare_reg_1 <= next_compare1;
        end
    end

    // sticky status; a new event wins over a write-one clear in the same cycle
    always_comb begin
        events = '0;
        events[`ST_MATCH0] = match0;
        events[`ST_MATCH1] = match1;
        events[`ST_OVERFLOW] = wrap;
        events[`ST_CAPTURE0] = cap0_hit;
        events[`ST_CAPTURE1] = cap1_hit;
        next_status = status;
        if (wr_access && is_reg(paddr, `OFS_STATUS)) begin
            next_status = status & ~pwdata[`ST_WIDTH-1:0];
        end
        next_status = next_status | events;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= '0;
        end else begin
            status <= next_status;
        end
    end

    // a set mask bit suppresses its source, a clear one lets it through
    assign irq = |(status & ~interrupt_mask_register);

    // read data is captured in the setup cycle so the access needs no wait state
    always_comb begin
        next_prdata = prdata;
        next_pslverr = 1'b0;
        if (setup) begin
            next_prdata = '0;
            next_pslverr = !mapped(paddr) || (paddr[1:0] != 2'h0);
            if (!pwrite) begin
                if (is_reg(paddr, `OFS_ENABLE)) begin
                    next_prdata[`ENABLE_BIT] = enable_register;
                end
                if (is_reg(paddr, `OFS_RUN)) begin
                    next_prdata[`RUN_PRESCALE_BIT] = run_register[1];
                    next_prdata[`RUN_COUNT_BIT] = run_register[0];
                end
                if (is_reg(paddr, `OFS_MODE)) begin
                    next_prdata[`MODE_WIDTH-1:0] = mode_register;
                end
                if (is_reg(paddr, `OFS_FFCTRL)) begin
                    next_prdata[`FF_WIDTH-1:0] = {flipflop_control[`FF_WIDTH-1:2], `FF_CMD_READ};
                end
                if (is_reg(paddr, `OFS_STATUS)) begin
                    next_prdata[`ST_WIDTH-1:0] = status;
                end
                if (is_reg(paddr, `OFS_MASK)) begin
                    next_prdata[`ST_WIDTH-1:0] = interrupt_mask_register;
                end
                if (is_reg(paddr, `OFS_COMPARE0)) begin
                    next_prdata[W-1:0] = compare_reg_0;
                end
                if (is_reg(paddr, `OFS_COMPARE1)) begin
                    next_prdata[W-1:0] = compare_reg_1;
                end
                if (is_reg(paddr, `OFS_CAPTURE0)) begin
                    next_prdata[W-1:0] = capture_reg_0;
                end
                if (is_reg(paddr, `OFS_CAPTURE1)) begin
                    next_prdata[W-1:0] = capture_reg_1;
                end
                if (is_reg(paddr, `OFS_COUNTER)) begin
                    next_prdata[W-1:0] = up_counter;
                end
            end
        end else if (psel && penable) begin
            next_pslverr = pslverr;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
            pslverr <= 1'b0;
        end else begin
            prdata <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

endmodule

// File: timer_capture_measure_checker.sv
// port-level assertions for the capture timer channel
`include "timer_capture_params.svh"
module capture_port_checker (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // pins
    input wire logic ext_capture_input,
    input wire logic companion_toggle_in,
    input wire logic toggle_flipflop,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic wr;
    logic [4:0] mask;
    logic [4:0] next_mask;
    logic [1:0] ffen;
    logic [1:0] next_ffen;
    logic [1:0] cpm;
    logic [1:0] next_cpm;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    assign wr = psel && penable && pwrite;
    // shadow copies of settings, since only the ports are visible here
    always_comb begin
        next_mask = mask;
        next_ffen = ffen;
        next_cpm = cpm;
        if (wr && paddr == `OFS_MASK) next_mask = pwdata[4:0];
        if (wr && paddr == `OFS_FFCTRL) next_ffen = pwdata[3:2];
        if (wr && paddr == `OFS_MODE) next_cpm = pwdata[5:4];
    end
    // shadow registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask <= 5'h00;
            ffen <= 2'h0;
            cpm <= 2'h0;
        end else begin
            mask <= next_mask;
            ffen <= next_ffen;
            cpm <= next_cpm;
        end
    end
    sequence bad_setup;
        psel && !penable && paddr[1:0] != 2'h0;
    endsequence
    // sync delay plus edge flop plus status register
    sequence irq_soon;
        ##[1:6] irq;
    endsequence
    chk_ready_high: assert property (pready) else $error("pready low");
    chk_unaligned_err: assert property (bad_setup |=> pslverr) else $error("no error on unaligned");
    chk_err_data: assert property (psel && penable && pslverr |-> prdata == 32'h0) else $error("data on error");
    chk_ff_hold: assert property (ffen == 2'h0 && !(wr && paddr == `OFS_FFCTRL) |=>
        $stable(toggle_flipflop)) else $error("flop moved while idle");
    chk_ff_clear: assert property (wr && paddr == `OFS_FFCTRL && pwdata[1:0] == 2'h2 |=>
        !toggle_flipflop) else $error("flop not cleared");
    chk_irq_masked: assert property (mask == 5'h1F |-> !irq) else $error("irq while all masked");
    chk_pin_rise: assert property (cpm == 2'h2 && !mask[3] && $rose(ext_capture_input) |->
        irq_soon) else $error("no capture0 event");
    chk_pin_fall: assert property (cpm == 2'h2 && !mask[4] && $fell(ext_capture_input) |->
        irq_soon) else $error("no capture1 event");
    chk_flop_rise: assert property (cpm == 2'h3 && !mask[3] && $rose(companion_toggle_in) |->
        irq_soon) else $error("no flop capture event");
endmodule

bind timer_capture_measure capture_port_checker capture_port_checker_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_capture_input(ext_capture_input),
    .companion_toggle_in(companion_toggle_in), .toggle_flipflop(toggle_flipflop), .irq(irq));

// File: pulse_partner.sv
// far-side source of the measured pin and the companion flop
module pulse_partner (
    // clock
    input wire logic pclk,
    // driven levels
    output logic ext_capture_input,
    output logic companion_toggle_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // both lines idle low from time zero
    initial begin
        ext_capture_input = 1'b0;
        companion_toggle_in = 1'b0;
    end
    // one high then low phase; phases kept longer than the sync delay
    task automatic pulse(input bit flop, input int hi, input int lo);
        if (flop) companion_toggle_in <= 1'b1;
        else ext_capture_input <= 1'b1;
        repeat (hi) @(posedge pclk);
        if (flop) companion_toggle_in <= 1'b0;
        else ext_capture_input <= 1'b0;
        repeat (lo) @(posedge pclk);
    endtask
endmodule

// File: tb_top.sv
// self-checking bench for the capture timer channel
`include "timer_capture_params.svh"
module tb_top import timer_capture_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DIV1 = 2;
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic pin;
    logic flop;
    logic toggle_flipflop;
    logic irq;
    int failures = 0;
    int checks_done = 0;
    int cycles = 0;
    timer_capture_measure #(.TAP1_DIV(DIV1)) timer_capture_measure_inst (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ext_capture_input(pin), .companion_toggle_in(flop),
        .toggle_flipflop(toggle_flipflop), .irq(irq));
    pulse_partner pulse_partner_inst (.pclk(pclk), .ext_capture_input(pin), .companion_toggle_in(flop));
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    task automatic final_report;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // hang guard, well above the few hundred cycles the tests need
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            $display("BAD %0t timeout", $time);
            final_report;
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // one apb transfer; an idle cycle after it keeps drives one per step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // pready high ends this wait, or else the bench timeout
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        logic e;
        apb(1'b0, a, 32'h0, q, e);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] q;
        rd(a, q);
        check(q, exp, what);
    endtask
    // run a pulse, then compare the captured span modulo the counter width
    task automatic span(input bit f, input int hi, input string what);
        logic [31:0] c0;
        logic [31:0] c1;
        logic [15:0] d;
        int x;
        pulse_partner_inst.pulse(f, hi, 10);
        rd(`OFS_CAPTURE0, c0);
        rd(`OFS_CAPTURE1, c1);
        d = c1[15:0] - c0[15:0];
        x = hi / DIV1;
        check({31'h0, d >= x - 1 && d <= x + 1}, 32'h1, what);
        rd(`OFS_STATUS, c0);
        check({30'h0, c0[4:3]}, 32'h3, "capture events");
        check({31'h0, irq}, 32'h1, "capture irq");
        wr(`OFS_RUN, 32'h0);
        wr(`OFS_STATUS, 32'h1F);
    endtask
    initial begin
        logic [31:0] q;
        logic e;
        int n;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // reset values, unmapped and unaligned places
        rd_chk(`OFS_MODE, 32'h0, "mode reset");
        rd_chk(`OFS_MASK, 32'h0, "mask reset");
        rd_chk(`OFS_FFCTRL, 32'h3, "ffctrl reset");
        rd_chk(`OFS_STATUS, 32'h0, "status reset");
        apb(1'b0, 8'h08, 32'h0, q, e);
        check({e, q[30:0]}, 32'h80000000, "unmapped read");
        apb(1'b1, 8'h19, 32'h1F, q, e);
        check({31'h0, e}, 32'h1, "unaligned write");
        rd_chk(`OFS_MASK, 32'h0, "mask untouched");
        wr(`OFS_COMPARE0, 32'h12345);
        rd_chk(`OFS_COMPARE0, 32'h2345, "compare width");
        // run needs both bits
        wr(`OFS_ENABLE, 32'h80);
        wr(`OFS_MODE, {29'h0, CLK_TAP1});
        wr(`OFS_RUN, 32'h01);
        repeat (20) @(posedge pclk);
        rd_chk(`OFS_COUNTER, 32'h0, "half run");
        wr(`OFS_RUN, 32'h05);
        repeat (20) @(posedge pclk);
        rd(`OFS_COUNTER, q);
        check({31'h0, q > 32'h7 && q < 32'h11}, 32'h1, "tap one count");
        wr(`OFS_RUN, 32'h0);
        rd_chk(`OFS_COUNTER, 32'h0, "stopped");
        // pin edges counted, no clear at compare match
        wr(`OFS_MODE, {26'h0, CPM_PIN_RISE, 1'b0, CLK_PIN});
        wr(`OFS_COMPARE1, 32'h2);
        wr(`OFS_RUN, 32'h05);
        repeat (5) pulse_partner_inst.pulse(1'b0, 4, 4);
        repeat (8) @(posedge pclk);
        rd_chk(`OFS_COUNTER, 32'h5, "pin count");
        // rise-only mode: last rise stores the count before its increment
        rd_chk(`OFS_CAPTURE0, 32'h4, "rise capture");
        rd_chk(`OFS_CAPTURE1, 32'h0, "rise only");
        // compare one match interrupt and masking
        wr(`OFS_RUN, 32'h0);
        wr(`OFS_STATUS, 32'h1F);
        wr(`OFS_MODE, {28'h1, CLK_TAP1});
        wr(`OFS_COMPARE1, 32'hA);
        wr(`OFS_MASK, 32'h1D);
        wr(`OFS_RUN, 32'h05);
        for (n = 0; n < 200 && irq !== 1'b1; n++) @(posedge pclk);
        check({31'h0, irq}, 32'h1, "match irq");
        rd(`OFS_STATUS, q);
        check({31'h0, q[1]}, 32'h1, "match status");
        wr(`OFS_MASK, 32'h1F);
        check({31'h0, irq}, 32'h0, "masked irq");
        wr(`OFS_RUN, 32'h0);
        wr(`OFS_STATUS, 32'h1F);
        rd_chk(`OFS_STATUS, 32'h0, "status cleared");
        // toggle flop on both matches, clear, hold and set commands
        wr(`OFS_COMPARE0, 32'h4);
        wr(`OFS_FFCTRL, 32'hE);
        check({31'h0, toggle_flipflop}, 32'h0, "flop cleared");
        wr(`OFS_RUN, 32'h05);
        for (n = 0; n < 100 && toggle_flipflop !== 1'b1; n++) @(posedge pclk);
        check({31'h0, toggle_flipflop}, 32'h1, "flop up");
        for (n = 0; n < 100 && toggle_flipflop !== 1'b0; n++) @(posedge pclk);
        check({31'h0, toggle_flipflop}, 32'h0, "flop down");
        repeat (7) @(posedge pclk);
        wr(`OFS_FFCTRL, 32'h3);
        e = toggle_flipflop;
        repeat (60) @(posedge pclk);
        check({31'h0, toggle_flipflop}, {31'h0, e}, "flop held");
        wr(`OFS_FFCTRL, 32'h1);
        check({31'h0, toggle_flipflop}, 32'h1, "flop set");
        wr(`OFS_FFCTRL, 32'h0);
        check({31'h0, toggle_flipflop}, 32'h0, "flop inverted");
        wr(`OFS_RUN, 32'h0);
        wr(`OFS_STATUS, 32'h1F);
        // pin rise and fall captures
        wr(`OFS_MASK, 32'h07);
        wr(`OFS_MODE, {26'h0, CPM_PIN_BOTH, 1'b0, CLK_TAP1});
        wr(`OFS_RUN, 32'h05);
        span(1'b0, 40, "pin span");
        // companion flop rise and fall captures
        wr(`OFS_MODE, {26'h0, CPM_FLOP_BOTH, 1'b0, CLK_TAP1});
        wr(`OFS_RUN, 32'h05);
        span(1'b1, 30, "flop span");
        final_report;
    end
endmodule
